//--- gcef_pkg.sv
// constants for the command event flag block: map, bits, codes.
// assumes a 32-bit AXI4-Lite slave with one aligned word per register.
package gcef_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h00; // status flags, clear on read
  localparam logic [7:0] ADDR_MASK_ONE   = 8'h04; // enables, write only
  localparam logic [7:0] ADDR_AUX_E      = 8'h08; // holdoff selects, bits 3-2
  localparam logic [7:0] ADDR_AUX_F      = 8'h0C; // holdoff selects, bits 3-0
  localparam logic [7:0] ADDR_MODE       = 8'h10; // addressing mode register
  localparam logic [7:0] ADDR_AUX_CMD    = 8'h14; // auxiliary command, write only
  localparam logic [7:0] ADDR_STATE      = 8'h18; // internal state, read only
  localparam logic [7:0] ADDR_PASS       = 8'h1C; // command pass register

  // flag and enable bit positions in status_one / mask_one
  localparam int BIT_GEX  = 7;
  localparam int BIT_ERR  = 6;
  localparam int BIT_UNK  = 5;
  localparam int BIT_SEC  = 4;
  localparam int BIT_DCLR = 3;
  localparam int BIT_OWN  = 2;

  // holdoff select bit positions
  localparam int BIT_HOLD_GEX    = 3; // aux e
  localparam int BIT_HOLD_CLEAR  = 2; // aux e
  localparam int BIT_HOLD_TALK   = 3; // aux f
  localparam int BIT_HOLD_LISTEN = 2; // aux f
  localparam int BIT_HOLD_UNADDR = 1; // aux f
  localparam int BIT_HOLD_ANY    = 0; // aux f

  // addressing mode register field
  localparam int BIT_XCVR_MODE = 5;

  // state register bits
  localparam int BIT_ST_HOLD = 0;
  localparam int BIT_ST_PASS = 1;
  localparam int BIT_ST_SEC  = 2;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // auxiliary commands written to ADDR_AUX_CMD
  localparam logic [7:0] AUX_SWRST     = 8'h02;
  localparam logic [7:0] AUX_RELEASE   = 8'h03;
  localparam logic [7:0] AUX_PASS_NEXT = 8'h0B;

  // bus command codes, seven bits, sent while attention is asserted
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_PPC = 7'h05;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_TCT = 7'h09;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_PPU = 7'h15;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;

  // command group tags in bits 6-4 / 6-5
  localparam logic [2:0] GRP_ACG = 3'h0;
  localparam logic [2:0] GRP_UCG = 3'h1;
  localparam logic [1:0] GRP_LAG = 2'h1;
  localparam logic [1:0] GRP_TAG = 2'h2;
  localparam logic [1:0] GRP_SCG = 2'h3;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gcef_pkg

//--- gcef_top.sv
// command event flag logic with AXI4-Lite register access.
// assumes one accept pulse per byte on i_clk_sys, stalled by holdoff.
//
// Function
// R1 - trigger flag enabled: holdoff, trigger high until release
// R2 - trigger flag disabled: one-cycle trigger pulse only
// R3 - trigger reaches shared pin only in trigger mode
// R4 - source delay with no acceptors sets error
// R5 - unknown universal or addressed command sets unrecognized
// R6 - pass-next aux command flags next secondary
// R7 - holdoff selects also raise unrecognized flag
// R8 - enabled flag setting, other than error, starts accepted holdoff
// R9 - holdoff kept until release aux command
// R10 - last passed command byte readable in pass register
// R11 - secondary pass enable selects secondary addressing
// R12 - secondary after own primary sets pass flag
// R13 - host checks pass flag before releasing holdoff
// R14 - device clear or listener selected clear sets flag
// R15 - own talk or listen address sets flag
// R16 - flags clear on reset or status read
// R17 - trigger command while listener sets trigger flag
// R18 - set during status read lands afterwards
// R19 - own address flag muted in poll/secondary mode
// R20 - interrupt when any enabled flag set
`timescale 1ns/10ps
module gcef_top
  import gcef_pkg::*;
#(
  parameter int AW = 8 // bus address width
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst_n,
  // axi4-lite slave
  input  wire logic [AW-1:0] i_awaddr,
  input  wire logic          i_awvalid,
  output logic               o_awready,
  input  wire logic [31:0]   i_wdata,
  input  wire logic [3:0]    i_wstrb,
  input  wire logic          i_wvalid,
  output logic               o_wready,
  output logic [1:0]         o_bresp,
  output logic               o_bvalid,
  input  wire logic          i_bready,
  input  wire logic [AW-1:0] i_araddr,
  input  wire logic          i_arvalid,
  output logic               o_arready,
  output logic [31:0]        o_rdata,
  output logic [1:0]         o_rresp,
  output logic               o_rvalid,
  input  wire logic          i_rready,
  // bus side status
  input  wire logic          i_cmd_accept,   // byte accepted, one pulse
  input  wire logic [7:0]    i_cmd_byte,     // byte on the data lines
  input  wire logic          i_atn,          // attention level
  input  wire logic          i_listener,     // listener addressed
  input  wire logic          i_talk_primary, // talker primary addressed
  input  wire logic          i_lstn_primary, // listener primary addressed
  input  wire logic          i_serial_poll,  // serial poll mode
  input  wire logic          i_pp1,          // parallel poll config state
  input  wire logic [4:0]    i_own_addr,     // own primary address
  input  wire logic          i_sdelay_enter, // source enters delay, pulse
  input  wire logic          i_external_accepted_seen,
  input  wire logic          i_ready_for_data,
  input  wire logic          i_xcvr_alt,     // pin level when not trigger
  // outputs
  output logic               o_dac_holdoff,
  output logic               o_trigger_output,
  output logic               o_shared_xcvr_pin,
  output logic               o_secondary_mode,
  output logic               o_irq
);

  //////////////////////////////////////////////////////////////////////
  // decode helpers

  // true when the seven-bit command equals a given code
  function automatic logic cmd_is(input logic [7:0] b, input logic [6:0] c);
    cmd_is = (b[6:0] == c);
  endfunction : cmd_is

  // register read/write address match on the word
  function automatic logic addr_is(input logic [AW-1:0] a,
                                   input logic [7:0]    o);
    addr_is = (a[7:2] == o[7:2]);
  endfunction : addr_is

  //////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] flags_ff,  nxt_flags;   // status_one
  logic [7:0] pend_ff,   nxt_pend;    // sets deferred by a read
  logic [7:0] mask_ff,   nxt_mask;    // mask_one
  logic [7:0] aux_e_ff,  nxt_aux_e;   // holdoff selects e
  logic [7:0] aux_f_ff,  nxt_aux_f;   // holdoff selects f
  logic [7:0] mode_ff,   nxt_mode;    // addressing mode
  logic [7:0] cpass_ff,  nxt_cpass;   // command pass register
  logic       hold_ff,   nxt_hold;    // accepted holdoff
  logic       pass_ff,   nxt_pass;    // pass next secondary state
  logic       thold_ff,  nxt_thold;   // trigger held high
  logic       tpulse_ff, nxt_tpulse;  // trigger single pulse
  logic       pin_ff,    nxt_pin;     // shared pin level
  logic       irq_ff,    nxt_irq;     // interrupt request

  // axi channel state
  logic          aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff;
  logic [AW-1:0] awaddr_ff;
  logic [31:0]   wdata_ff,  rdata_ff;
  logic [3:0]    wstrb_ff;
  logic [1:0]    bresp_ff,  rresp_ff;

  //////////////////////////////////////////////////////////////////////
  // command decode

  wire        acc      = i_cmd_accept & i_atn;      // command accepted
  wire [7:0]  b        = i_cmd_byte;
  wire        is_ucg   = (b[6:4] == GRP_UCG);
  wire        is_acg   = (b[6:4] == GRP_ACG);
  wire        is_lag   = (b[6:5] == GRP_LAG);
  wire        is_tag   = (b[6:5] == GRP_TAG);
  wire        is_scg   = (b[6:5] == GRP_SCG);
  wire        c_get    = cmd_is(b, CMD_GET);
  wire        c_sdc    = cmd_is(b, CMD_SDC);
  wire        c_dcl    = cmd_is(b, CMD_DCL);
  wire        c_unl    = cmd_is(b, CMD_UNL);
  wire        c_unt    = cmd_is(b, CMD_UNT);
  wire        ucg_known = cmd_is(b, CMD_LLO) | cmd_is(b, CMD_SPE)
                        | cmd_is(b, CMD_SPD) | c_dcl
                        | (cmd_is(b, CMD_PPU) & i_pp1);
  wire        acg_known = c_get | cmd_is(b, CMD_GTL) | c_sdc
                        | cmd_is(b, CMD_TCT)
                        | (cmd_is(b, CMD_PPC) & i_pp1);
  wire        own_lstn = is_lag & (b[4:0] == i_own_addr);
  wire        own_talk = is_tag & (b[4:0] == i_own_addr);
  wire        sec_en   = mask_ff[BIT_SEC];           // [R11]

  // individual flag set conditions
  wire set_gex  = acc & c_get & i_listener;                      // [R17]
  wire set_err  = i_sdelay_enter & i_external_accepted_seen
                & i_ready_for_data;                              // [R4]
  wire unk_base = (acc & is_ucg & ~ucg_known)                    // [R5]
                | (acc & is_acg & ~acg_known & i_listener)       // [R5]
                | (acc & is_scg & pass_ff);                      // [R6]
  wire unk_sel  = (aux_e_ff[BIT_HOLD_GEX] & acc & c_get)         // [R7]
                | (aux_e_ff[BIT_HOLD_CLEAR] & acc & (c_sdc | c_dcl))
                | (aux_f_ff[BIT_HOLD_TALK] & acc & is_tag & ~c_unt)
                | (aux_f_ff[BIT_HOLD_LISTEN] & acc & is_lag & ~c_unl)
                | (aux_f_ff[BIT_HOLD_UNADDR] & acc & (c_unt | c_unl))
                | (aux_f_ff[BIT_HOLD_ANY] & acc);
  wire set_unk  = unk_base | unk_sel;
  wire set_sec  = acc & is_scg
                & (i_talk_primary | i_lstn_primary);             // [R12]
  wire set_dclr = acc & (c_dcl | (c_sdc & i_listener));          // [R14]
  wire set_own  = acc & (own_talk | own_lstn)                    // [R15]
                & ~i_serial_poll & ~sec_en;                      // [R19]

  wire [7:0] set_vec;
  assign set_vec[BIT_GEX]  = set_gex;
  assign set_vec[BIT_ERR]  = set_err;
  assign set_vec[BIT_UNK]  = set_unk;
  assign set_vec[BIT_SEC]  = set_sec;
  assign set_vec[BIT_DCLR] = set_dclr;
  assign set_vec[BIT_OWN]  = set_own;
  assign set_vec[1:0]      = 2'h0; // poll and clear flags live elsewhere

  // flags that hold off the handshake when enabled; error does not
  wire [7:0] hold_src = set_vec & mask_ff & ~(8'h01 << BIT_ERR);
  wire       hold_set = |hold_src;                               // [R1] [R8]

  //////////////////////////////////////////////////////////////////////
  // bus access decode

  wire ar_go  = i_arvalid & ~rvalid_ff;             // read taken now
  wire wr_go  = aw_have_ff & w_have_ff & ~bvalid_ff; // write performed
  wire lane0  = wr_go & wstrb_ff[0];                 // low byte written
  wire rd_st  = ar_go & addr_is(i_araddr, ADDR_STATUS_ONE);
  wire wr_msk = lane0 & addr_is(awaddr_ff, ADDR_MASK_ONE);
  wire wr_e   = lane0 & addr_is(awaddr_ff, ADDR_AUX_E);
  wire wr_f   = lane0 & addr_is(awaddr_ff, ADDR_AUX_F);
  wire wr_adm = lane0 & addr_is(awaddr_ff, ADDR_MODE);
  wire wr_aux = lane0 & addr_is(awaddr_ff, ADDR_AUX_CMD);
  wire swrst  = wr_aux & (wdata_ff[7:0] == AUX_SWRST);
  wire rel    = wr_aux & (wdata_ff[7:0] == AUX_RELEASE);
  wire pnext  = wr_aux & (wdata_ff[7:0] == AUX_PASS_NEXT);

  wire w_mapped = addr_is(awaddr_ff, ADDR_MASK_ONE)
                | addr_is(awaddr_ff, ADDR_AUX_E)
                | addr_is(awaddr_ff, ADDR_AUX_F)
                | addr_is(awaddr_ff, ADDR_MODE)
                | addr_is(awaddr_ff, ADDR_AUX_CMD);

  // read mux; write-only registers read as zero
  logic [7:0] rd_byte;
  logic       r_mapped;
  wire  [7:0] state_byte = {5'h0, sec_en, pass_ff, hold_ff};

  always_comb begin
    rd_byte  = RST_BYTE;
    r_mapped = 1'b1;
    case (i_araddr[7:2])
      ADDR_STATUS_ONE[7:2]: rd_byte = flags_ff;
      ADDR_MASK_ONE[7:2]:   rd_byte = RST_BYTE;
      ADDR_AUX_E[7:2]:      rd_byte = aux_e_ff;
      ADDR_AUX_F[7:2]:      rd_byte = aux_f_ff;
      ADDR_MODE[7:2]:       rd_byte = mode_ff;
      ADDR_AUX_CMD[7:2]:    rd_byte = RST_BYTE;
      ADDR_STATE[7:2]:      rd_byte = state_byte;
      ADDR_PASS[7:2]:       rd_byte = cpass_ff;
      default:              r_mapped = 1'b0; // unmapped answers error
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // next-state logic for the event flags

  always_comb begin
    // a read clears the flags; sets in that cycle park one cycle
    if (rd_st) begin
      nxt_flags = pend_ff;                        // [R16] [R18]
      nxt_pend  = set_vec;                        // [R18]
    end else begin
      nxt_flags = flags_ff | pend_ff | set_vec;
      nxt_pend  = RST_BYTE;
    end
    if (swrst) begin
      nxt_flags = RST_BYTE;                       // [R16]
      nxt_pend  = RST_BYTE;
    end
  end

  // holdoff: a new set wins over a release in the same cycle
  assign nxt_hold = hold_set | (hold_ff & ~rel & ~swrst);      // [R8] [R9]

  // trigger held while enabled holdoff lasts, else a single pulse
  assign nxt_thold  = (set_gex & mask_ff[BIT_GEX])
                    | (thold_ff & ~rel & ~swrst);               // [R1]
  assign nxt_tpulse = set_gex & ~mask_ff[BIT_GEX];              // [R2]

  // shared pin carries the trigger only in trigger mode
  assign nxt_pin = mode_ff[BIT_XCVR_MODE]
                 ? (nxt_thold | nxt_tpulse) : i_xcvr_alt;       // [R3]

  // pass next secondary ends on the first secondary accepted
  assign nxt_pass = pnext | (pass_ff & ~(acc & is_scg) & ~swrst); // [R6]

  // capture the byte behind a pass or unrecognized event
  assign nxt_cpass = (set_unk | set_sec) ? b : cpass_ff;  // [R10] [R12]

  // interrupt request from any enabled flag
  assign nxt_irq = |(nxt_flags & mask_ff);                      // [R20]

  // software writes
  assign nxt_mask  = wr_msk ? wdata_ff[7:0] : mask_ff;          // [R11]
  assign nxt_aux_e = wr_e   ? wdata_ff[7:0] : aux_e_ff;
  assign nxt_aux_f = wr_f   ? wdata_ff[7:0] : aux_f_ff;
  assign nxt_mode  = wr_adm ? wdata_ff[7:0] : mode_ff;

  //////////////////////////////////////////////////////////////////////
  // block registers

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      flags_ff  <= RST_BYTE;
      pend_ff   <= RST_BYTE;
      mask_ff   <= RST_BYTE;
      aux_e_ff  <= RST_BYTE;
      aux_f_ff  <= RST_BYTE;
      mode_ff   <= RST_BYTE;
      cpass_ff  <= RST_BYTE;
    end else begin
      flags_ff  <= nxt_flags;
      pend_ff   <= nxt_pend;
      mask_ff   <= nxt_mask;
      aux_e_ff  <= nxt_aux_e;
      aux_f_ff  <= nxt_aux_f;
      mode_ff   <= nxt_mode;
      cpass_ff  <= nxt_cpass;
    end
  end

  // single-bit control state
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      hold_ff   <= 1'b0;
      pass_ff   <= 1'b0;
      thold_ff  <= 1'b0;
      tpulse_ff <= 1'b0;
      pin_ff    <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      hold_ff   <= nxt_hold;
      pass_ff   <= nxt_pass;
      thold_ff  <= nxt_thold;
      tpulse_ff <= nxt_tpulse;
      pin_ff    <= nxt_pin;
      irq_ff    <= nxt_irq;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // axi4-lite write channels; address and data accepted in either order

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
    end else begin
      // capture each channel when offered and idle
      if (i_awvalid && !aw_have_ff) begin
        aw_have_ff <= 1'b1;
        awaddr_ff  <= i_awaddr;
      end else if (wr_go) begin
        aw_have_ff <= 1'b0;
      end
      if (i_wvalid && !w_have_ff) begin
        w_have_ff <= 1'b1;
        wdata_ff  <= i_wdata;
        wstrb_ff  <= i_wstrb;
      end else if (wr_go) begin
        w_have_ff <= 1'b0;
      end
      // response one cycle after both halves are held
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // axi4-lite read channel; data sampled at the address handshake

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (ar_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h000000, rd_byte};
      rresp_ff  <= r_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign o_awready         = ~aw_have_ff;
  assign o_wready          = ~w_have_ff;
  assign o_bvalid          = bvalid_ff;
  assign o_bresp           = bresp_ff;
  assign o_arready         = ~rvalid_ff;
  assign o_rvalid          = rvalid_ff;
  assign o_rdata           = rdata_ff;
  assign o_rresp           = rresp_ff;
  assign o_dac_holdoff     = hold_ff;                       // [R9]
  assign o_trigger_output  = thold_ff | tpulse_ff;          // [R1] [R2]
  assign o_shared_xcvr_pin = pin_ff;
  assign o_secondary_mode  = sec_en;                        // [R11]
  assign o_irq             = irq_ff;

endmodule : gcef_top

//--- gcef_sva.sv
// checker for the command event flag block, port level only
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/10ps
module gcef_sva
  import gcef_pkg::*;
(
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  input wire logic       i_awvalid,
  input wire logic       o_awready,
  input wire logic       i_wvalid,
  input wire logic       o_wready,
  input wire logic       o_bvalid,
  input wire logic       i_arvalid,
  input wire logic       o_arready,
  input wire logic       o_rvalid,
  input wire logic       i_cmd_accept,
  input wire logic [7:0] i_cmd_byte,
  input wire logic       i_atn,
  input wire logic       i_listener,
  input wire logic       o_dac_holdoff,
  input wire logic       o_trigger_output,
  input wire logic       o_secondary_mode,
  input wire logic       o_irq
);
  ////////////////////////////////////////////////////////////////////////
  // one domain: clock and reset given once
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // a set may slip one edge behind a status read
  a_gex_on_get: assert property (i_cmd_accept && i_atn && i_listener &&
    i_cmd_byte[6:0] == CMD_GET |=> ##[0:1] o_trigger_output)
    else $error("trigger missing after group trigger");
  a_gex_pulse: assert property ($rose(o_trigger_output) && !o_dac_holdoff
    |=> !o_trigger_output) else $error("trigger pulse too long");
  a_gex_level: assert property (o_trigger_output && o_dac_holdoff &&
    $past(o_trigger_output) |=> o_trigger_output || !o_dac_holdoff)
    else $error("trigger level dropped during holdoff");
  // release comes only by a bus write
  a_hold_keep: assert property (o_dac_holdoff && !$past(i_awvalid) &&
    !$past(i_wvalid) |=> o_dac_holdoff) else $error("holdoff dropped without write");
  a_hold_cause: assert property ($rose(o_dac_holdoff) |-> $past(i_cmd_accept) ||
    $past(i_cmd_accept, 2)) else $error("holdoff without accepted byte");
  a_hold_irq: assert property ($rose(o_dac_holdoff) |-> ##[0:2] o_irq)
    else $error("no interrupt for enabled flag");
  a_sec_mode: assert property ($changed(o_secondary_mode) |->
    $past(i_awvalid, 2) || $past(i_awvalid, 3)) else $error("mode changed without write");
  a_read_lat: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  a_write_lat: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |=> ##1 o_bvalid) else $error("write answer late");

  c_hold_gex: cover property (o_dac_holdoff && o_trigger_output);
  c_irq: cover property ($rose(o_irq));
  c_sec: cover property (o_secondary_mode && o_dac_holdoff);
endmodule : gcef_sva

bind gcef_top gcef_sva u_sva (.i_clk_sys, .i_rst_n, .i_awvalid, .o_awready, .i_wvalid,
  .o_wready, .o_bvalid, .i_arvalid, .o_arready, .o_rvalid, .i_cmd_accept, .i_cmd_byte,
  .i_atn, .i_listener, .o_dac_holdoff, .o_trigger_output, .o_secondary_mode, .o_irq);

//--- gcef_ctrl_model.sv
// bus controller model: sends command bytes with attention asserted
// assumes the device holdoff is visible as a level on i_holdoff
`timescale 1ns/10ps
module gcef_ctrl_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_holdoff,
  output logic            o_atn,
  output logic            o_accept,
  output logic [7:0]      o_byte
);
  initial begin
    o_atn    = 1'b0;
    o_accept = 1'b0;
    o_byte   = 8'h00;
  end

  // random gap: prompt and slow controller
  task automatic send(input logic [7:0] b);
    int n;
    n = $urandom_range(0, 3);
    @(posedge i_clk_sys);
    o_atn  <= 1'b1;
    o_byte <= b;
    repeat (n) @(posedge i_clk_sys);
    while (i_holdoff) @(posedge i_clk_sys); // no new byte while held off
    o_accept <= 1'b1;
    @(posedge i_clk_sys);
    o_accept <= 1'b0;
    o_atn    <= 1'b0;
    o_byte   <= ~b; // released lines lose the byte
  endtask : send
endmodule : gcef_ctrl_model

//--- gcef_bench.sv
// self-checking bench for the command event flag block
// assumes the controller model and the bound checker are compiled alongside
`timescale 1ns/10ps
module gcef_bench;
  import gcef_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        listener = 0, lpri = 0, spoll = 0, pp1 = 0, sdly = 0, xdac = 0, rfd = 0;
  logic        alt = 0;
  logic [4:0]  own = 5'h00;
  logic        awready, wready, bvalid, arready, rvalid, hold, tout, pin, secm, irq;
  logic        atn, acc;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  cbyte;
  logic [33:0] exp_q[$];
  int          error_cnt = 0, checks = 0, tcnt = 0;
  // command table: pp1, listener, byte, expected status
  logic [17:0] tbl[14] = '{18'h01320, 18'h01100, 18'h01800, 18'h01900, 18'h01408,
    18'h10408, 18'h00400, 18'h10220, 18'h00200, 18'h10100, 18'h10900, 18'h01520,
    18'h21500, 18'h30500};
  // holdoff selects: reg f, select, listener, byte, expected status
  logic [21:0] ht[6] = '{22'h1108A0, 22'h081428, 22'h305E20, 22'h283E20,
    22'h243F20, 22'h221120};

  initial forever #5 clk = ~clk;

  gcef_top u_gcef_top (.i_clk_sys(clk), .i_rst_n(rst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_cmd_accept(acc), .i_cmd_byte(cbyte), .i_atn(atn), .i_listener(listener),
    .i_talk_primary(1'b0), .i_lstn_primary(lpri), .i_serial_poll(spoll), .i_pp1(pp1),
    .i_own_addr(own), .i_sdelay_enter(sdly), .i_external_accepted_seen(xdac),
    .i_ready_for_data(rfd), .i_xcvr_alt(alt), .o_dac_holdoff(hold),
    .o_trigger_output(tout), .o_shared_xcvr_pin(pin), .o_secondary_mode(secm),
    .o_irq(irq));
  gcef_ctrl_model u_gcef_ctrl_model (.i_clk_sys(clk), .i_holdoff(hold), .o_atn(atn),
    .o_accept(acc), .o_byte(cbyte));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // reads the level settled before the next edge
  task automatic chk_pin(ref logic g, input logic e);
    @(posedge clk);
    chk({33'h0, g}, {33'h0, e});
  endtask : chk_pin
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge clk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awready) begin ad = 1; awvalid <= 0; end
      if (!dd && wready) begin dd = 1; wvalid <= 0; end
    end
    while (!bvalid) @(posedge clk);
    chk({32'h0, bresp}, {32'h0, r});
    bready <= 0;
  endtask : wr
  // expected word queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    exp_q.push_back({r, 24'h0, d});
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    rready <= 0;
  endtask : rd
  task automatic cmd(input logic [7:0] b);
    u_gcef_ctrl_model.send(b);
  endtask : cmd
  task automatic results;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  always @(posedge clk) if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
  always @(posedge clk) tcnt <= tcnt + (tout === 1'b1);
  // a few hundred cycles needed
  initial begin
    #300000;
    error_cnt++;
    $display("Error at %0t: timeout", $time);
    results();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int c0;
    void'($urandom(32'h9F1AF9DD));
    own = 5'($urandom_range(0, 29)); // clear of address 30
    alt = 1'($urandom_range(0, 1));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_STATUS_ONE, 8'h00, RESP_OKAY);
    rd(ADDR_MASK_ONE, 8'h00, RESP_OKAY);
    rd(8'h24, 8'h00, RESP_SLVERR);
    wr(8'h24, 8'hFF, RESP_SLVERR);
    chk_pin(pin, alt);
    $display("test reset done");
    listener <= 1;
    c0 = tcnt;
    cmd(8'h08);
    rd(ADDR_STATUS_ONE, 8'h80, RESP_OKAY);
    rd(ADDR_STATUS_ONE, 8'h00, RESP_OKAY);
    chk(34'(tcnt - c0), 34'd1);
    chk_pin(hold, 1'b0);
    wr(ADDR_MODE, 8'h20, RESP_OKAY);
    wr(ADDR_MASK_ONE, 8'h80, RESP_OKAY);
    cmd(8'h08);
    chk_pin(hold, 1'b1);
    chk_pin(irq, 1'b1);
    rd(ADDR_STATUS_ONE, 8'h80, RESP_OKAY);
    chk_pin(tout, 1'b1);
    chk_pin(pin, 1'b1);
    wr(ADDR_AUX_CMD, AUX_RELEASE, RESP_OKAY);
    chk_pin(tout, 1'b0);
    wr(ADDR_MASK_ONE, 8'h00, RESP_OKAY);
    wr(ADDR_MODE, 8'h00, RESP_OKAY);
    chk_pin(pin, alt);
    $display("test trigger done");
    foreach (tbl[i]) begin
      pp1 <= tbl[i][17];
      listener <= tbl[i][16];
      cmd(tbl[i][15:8]);
      rd(ADDR_STATUS_ONE, tbl[i][7:0], RESP_OKAY);
      if (tbl[i][5]) rd(ADDR_PASS, tbl[i][15:8], RESP_OKAY);
    end
    listener <= 0;
    cmd({3'h1, own});
    rd(ADDR_STATUS_ONE, 8'h04, RESP_OKAY);
    cmd({3'h2, own});
    rd(ADDR_STATUS_ONE, 8'h04, RESP_OKAY);
    cmd(8'h3E);
    rd(ADDR_STATUS_ONE, 8'h00, RESP_OKAY);
    spoll <= 1;
    cmd({3'h1, own});
    rd(ADDR_STATUS_ONE, 8'h00, RESP_OKAY);
    spoll <= 0;
    $display("test commands done");
    xdac <= 1;
    for (int k = 0; k < 2; k++) begin
      rfd <= (k == 0);
      @(posedge clk) sdly <= 1;
      @(posedge clk) sdly <= 0;
      rd(ADDR_STATUS_ONE, k ? 8'h00 : 8'h40, RESP_OKAY);
    end
    $display("test error done");
    wr(ADDR_MASK_ONE, 8'h10, RESP_OKAY);
    chk_pin(secm, 1'b1);
    cmd({3'h1, own});
    lpri <= 1;
    cmd(8'h65);
    chk_pin(hold, 1'b1);
    rd(ADDR_STATUS_ONE, 8'h10, RESP_OKAY);
    rd(ADDR_PASS, 8'h65, RESP_OKAY);
    wr(ADDR_AUX_CMD, AUX_RELEASE, RESP_OKAY);
    chk_pin(hold, 1'b0);
    lpri <= 0;
    wr(ADDR_MASK_ONE, 8'h00, RESP_OKAY);
    wr(ADDR_AUX_CMD, AUX_PASS_NEXT, RESP_OKAY);
    cmd(8'h65);
    rd(ADDR_STATUS_ONE, 8'h20, RESP_OKAY);
    cmd(8'h66);
    rd(ADDR_STATUS_ONE, 8'h00, RESP_OKAY);
    $display("test secondary done");
    foreach (ht[i]) begin
      wr(ht[i][21] ? ADDR_AUX_F : ADDR_AUX_E, {4'h0, ht[i][20:17]}, RESP_OKAY);
      listener <= ht[i][16];
      cmd(ht[i][15:8]);
      rd(ADDR_STATUS_ONE, ht[i][7:0], RESP_OKAY);
      wr(ht[i][21] ? ADDR_AUX_F : ADDR_AUX_E, 8'h00, RESP_OKAY);
    end
    $display("test holdoff selects done");
    cmd(8'h14);
    wr(ADDR_AUX_CMD, AUX_SWRST, RESP_OKAY);
    rd(ADDR_STATUS_ONE, 8'h00, RESP_OKAY);
    $display("test software reset done");
    results();
  end
endmodule : gcef_bench
